// ---- rtl/nrb_params.svh ----
// Purpose: Constants for the nibble rotate and bit test unit.
// Assumes: Byte-wide opcode stream, one state per clock.
// Notes: Flag bit positions follow the usual S Z - H - PV N C layout.
`ifndef NRB_PARAMS_SVH
`define NRB_PARAMS_SVH
`define NRB_PFX_ED      8'hED
`define NRB_PFX_CB      8'hCB
`define NRB_PFX_DD      8'hDD
`define NRB_PFX_FD      8'hFD
`define NRB_OP_ROT_R    8'h67
`define NRB_OP_ROT_L    8'h6F
`define NRB_BIT_GROUP   2'h1
`define NRB_SEL_MEM     3'h6
`define NRB_SEL_ACC     3'h7
`define NRB_FLAG_S      7
`define NRB_FLAG_Z      6
`define NRB_FLAG_H      4
`define NRB_FLAG_PV     2
`define NRB_FLAG_N      1
`define NRB_FLAG_C      0
`define NRB_T_ROT       5'd18
`define NRB_T_BIT_REG   5'd8
`define NRB_T_BIT_PTR   5'd12
`define NRB_T_BIT_IDX   5'd20
`define NRB_T_MEM_RD    5'd11
`define NRB_T_ROT_WR    5'd15
`endif

// ---- rtl/nrb_pkg.sv ----
// Purpose: Types for the nibble rotate and bit test unit.
// Assumes: Nothing beyond the constants header.
// Notes: Register file travels as one packed struct.
package nrb_pkg;
	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  flags;
		logic [7:0]  b;
		logic [7:0]  c;
		logic [7:0]  d;
		logic [7:0]  e;
		logic [7:0]  h;
		logic [7:0]  l;
		logic [15:0] first_index_pair;
		logic [15:0] second_index_pair;
	} nrb_regs_t;
	typedef enum logic [2:0] {
		NRB_NONE,
		NRB_ROT_R,
		NRB_ROT_L,
		NRB_BIT_REG,
		NRB_BIT_PTR,
		NRB_BIT_IDX
	} nrb_op_t;
	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} nrb_mem_req_t;
endpackage : nrb_pkg

// ---- rtl/nrb_decode.sv ----
// Purpose: Decodes an opcode sequence into an operation and its operand fields.
// Assumes: Prefix and second bytes are presented together with the fourth byte.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "nrb_params.svh"
module nrb_decode
(
	// Opcode bytes.
	input  wire logic [7:0]      pfx,
	input  wire logic [7:0]      op2,
	input  wire logic [7:0]      op4,
	// Decoded operation.
	output nrb_pkg::nrb_op_t     op,
	output logic      [2:0]      bit_sel,
	output logic      [2:0]      reg_sel,
	output logic                 use_second
);
	logic [7:0] bit_op;

	// The indexed form carries its bit opcode in the fourth byte.
	always_comb
	begin
		bit_op     = ((pfx == `NRB_PFX_DD) || (pfx == `NRB_PFX_FD)) ? op4 : op2;
		bit_sel    = bit_op[5:3];
		reg_sel    = bit_op[2:0];
		use_second = (pfx == `NRB_PFX_FD);
		op         = nrb_pkg::NRB_NONE;
		if (pfx == `NRB_PFX_ED && op2 == `NRB_OP_ROT_R)
			op = nrb_pkg::NRB_ROT_R;
		else if (pfx == `NRB_PFX_ED && op2 == `NRB_OP_ROT_L)
			op = nrb_pkg::NRB_ROT_L;
		else if (pfx == `NRB_PFX_CB && op2[7:6] == `NRB_BIT_GROUP && op2[2:0] == `NRB_SEL_MEM)
			op = nrb_pkg::NRB_BIT_PTR;
		else if (pfx == `NRB_PFX_CB && op2[7:6] == `NRB_BIT_GROUP && op2[2:0] != 3'h6)
			op = nrb_pkg::NRB_BIT_REG;
		else if ((pfx == `NRB_PFX_DD || pfx == `NRB_PFX_FD) && op2 == `NRB_PFX_CB
			&& op4[7:6] == `NRB_BIT_GROUP && op4[2:0] == `NRB_SEL_MEM)
			op = nrb_pkg::NRB_BIT_IDX;
	end
endmodule : nrb_decode

// ---- rtl/nrb_unit.sv ----
// Purpose: Executes nibble rotates and bit tests, one clock per clock state.
// Assumes: Memory answers a read within the cycle that mem_r.rd is high.
// Notes: Register code 110 outside the memory forms is not a register test.
// How it works
// - Right rotate: mem low to acc low, acc low to mem high, mem high to low.
// - Right rotate keeps acc high nibble; operand lives at the pointer pair address.
// - Right rotate is prefix ED then 67.
// - Right rotate lasts 18 states over 5 machine cycles.
// - Rotate sets sign from acc bit 7 and zero when acc is zero.
// - Rotate sets parity on even acc, clears half and subtract, keeps carry.
// - Register bit test is CB then 01, bit field, register field.
// - Register codes 000 to 101 are B to L, 111 is acc.
// - Bit test sets zero to inverted bit, sets half, clears subtract, keeps carry.
// - Bit test changes only the flags.
// - Pointer bit test is CB, 01 bbb 110, byte at pointer pair.
// - Pointer bit test lasts 12 states.
// - First indexed test: DD CB d op; address is first pair plus signed d.
// - Second indexed test uses FD and the second index pair.
// - Indexed bit test lasts 20 states.
// - Left rotate 6F: mem low to high, mem high to acc, acc to mem low.
`timescale 1ns/1ps
`include "nrb_params.svh"
module nrb_unit
(
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  srst,
	// Instruction start.
	input  wire logic                  start,
	input  wire logic [7:0]            pfx,
	input  wire logic [7:0]            op2,
	input  wire logic [7:0]            disp,
	input  wire logic [7:0]            op4,
	// Register file in.
	input  wire nrb_pkg::nrb_regs_t    regs_in,
	// Memory data.
	input  wire logic [7:0]            mem_rdata,
	// Memory request.
	output nrb_pkg::nrb_mem_req_t      mem_r,
	// Results.
	output logic      [7:0]            acc_r,
	output logic      [7:0]            flags_r,
	output logic                       busy_r,
	output logic                       done_r,
	output logic                       illegal_r
);
	typedef enum logic [1:0] {NRB_IDLE, NRB_RUN} nrb_st_t;
	nrb_st_t          st_r;
	nrb_pkg::nrb_op_t dop;
	nrb_pkg::nrb_op_t op_r;
	logic [2:0]       bit_sel;
	logic [2:0]       reg_sel;
	logic [2:0]       bit_r;
	logic [7:0]       byte_r;
	logic             use_second;
	logic [4:0]       cnt_r;
	logic [4:0]       len_nxt;
	logic [4:0]       len_r;
	logic [7:0]       reg_val;
	logic [7:0]       mdat_r;
	logic [15:0]      idx_base;
	logic [7:0]       acc_nxt;
	logic [7:0]       mem_nxt;
	logic [7:0]       flags_nxt;
	logic [7:0]       tst;

	nrb_decode nrb_decode_i
	(
		.pfx        (pfx),
		.op2        (op2),
		.op4        (op4),
		.op         (dop),
		.bit_sel    (bit_sel),
		.reg_sel    (reg_sel),
		.use_second (use_second)
	);

	// Operand selection and instruction length.
	always_comb
	begin
		unique case (reg_sel)
			3'h0: reg_val = regs_in.b;
			3'h1: reg_val = regs_in.c;
			3'h2: reg_val = regs_in.d;
			3'h3: reg_val = regs_in.e;
			3'h4: reg_val = regs_in.h;
			3'h5: reg_val = regs_in.l;
			default: reg_val = regs_in.acc;
		endcase
		idx_base = use_second ? regs_in.second_index_pair : regs_in.first_index_pair;
		unique case (dop)
			nrb_pkg::NRB_ROT_R, nrb_pkg::NRB_ROT_L: len_nxt = `NRB_T_ROT;
			nrb_pkg::NRB_BIT_REG: len_nxt = `NRB_T_BIT_REG;
			nrb_pkg::NRB_BIT_PTR: len_nxt = `NRB_T_BIT_PTR;
			nrb_pkg::NRB_BIT_IDX: len_nxt = `NRB_T_BIT_IDX;
			default: len_nxt = 5'h00;
		endcase
	end

	// Result computation for the finishing state.
	always_comb
	begin
		acc_nxt   = acc_r;
		mem_nxt   = mdat_r;
		flags_nxt = flags_r;
		tst       = (op_r == nrb_pkg::NRB_BIT_REG) ? byte_r : mdat_r;
		if (op_r == nrb_pkg::NRB_ROT_R)
		begin
			acc_nxt = {acc_r[7:4], mdat_r[3:0]};
			mem_nxt = {acc_r[3:0], mdat_r[7:4]};
		end
		else if (op_r == nrb_pkg::NRB_ROT_L)
		begin
			acc_nxt = {acc_r[7:4], mdat_r[7:4]};
			mem_nxt = {mdat_r[3:0], acc_r[3:0]};
		end
		if (op_r == nrb_pkg::NRB_ROT_R || op_r == nrb_pkg::NRB_ROT_L)
		begin
			flags_nxt[`NRB_FLAG_S]  = acc_nxt[7];
			flags_nxt[`NRB_FLAG_Z]  = (acc_nxt == 8'h00);
			flags_nxt[`NRB_FLAG_PV] = ~(^acc_nxt);
			flags_nxt[`NRB_FLAG_H]  = 1'b0;
			flags_nxt[`NRB_FLAG_N]  = 1'b0;
		end
		else
		begin
			flags_nxt[`NRB_FLAG_Z] = ~tst[bit_r];
			flags_nxt[`NRB_FLAG_H] = 1'b1;
			flags_nxt[`NRB_FLAG_N] = 1'b0;
		end
	end

	// Sequencer: counts clock states from the instruction start.
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			st_r      <= NRB_IDLE;
			cnt_r     <= 5'h00;
			len_r     <= 5'h00;
			op_r      <= nrb_pkg::NRB_NONE;
			bit_r     <= 3'h0;
			byte_r    <= 8'h00;
			busy_r    <= 1'b0;
			done_r    <= 1'b0;
			illegal_r <= 1'b0;
		end
		else
		begin
			done_r    <= 1'b0;
			illegal_r <= 1'b0;
			unique case (st_r)
				NRB_IDLE:
					if (start && dop == nrb_pkg::NRB_NONE)
						illegal_r <= 1'b1;
					else if (start)
					begin
						st_r   <= NRB_RUN;
						op_r   <= dop;
						len_r  <= len_nxt;
						bit_r  <= bit_sel;
						byte_r <= reg_val;
						cnt_r  <= 5'h01;
						busy_r <= 1'b1;
					end
				NRB_RUN:
					if (cnt_r == len_r)
					begin
						st_r   <= NRB_IDLE;
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
					else
						cnt_r <= cnt_r + 5'h01;
			endcase
		end
	end

	// Memory access: read at state 11 (state 8 for the pointer test), write back at 15 for rotates.
	always_ff @(posedge clock)
	begin
		if (srst)
			mem_r <= '0;
		else if (st_r == NRB_IDLE && start)
		begin
			mem_r.rd <= 1'b0;
			mem_r.wr <= 1'b0;
			if (dop == nrb_pkg::NRB_BIT_IDX)
				mem_r.addr <= idx_base + {{8{disp[7]}}, disp};
			else
				mem_r.addr <= {regs_in.h, regs_in.l};
		end
		else
		begin
			mem_r.rd <= st_r == NRB_RUN && op_r != nrb_pkg::NRB_BIT_REG
				&& cnt_r == (len_r == `NRB_T_BIT_PTR ? 5'd7 : `NRB_T_MEM_RD - 5'd1);
			mem_r.wr <= st_r == NRB_RUN && cnt_r == `NRB_T_ROT_WR - 5'd1
				&& (op_r == nrb_pkg::NRB_ROT_R || op_r == nrb_pkg::NRB_ROT_L);
			mem_r.wdata <= mem_nxt;
		end
	end

	// Captures read data and commits results at the last state.
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mdat_r  <= 8'h00;
			acc_r   <= 8'h00;
			flags_r <= 8'h00;
		end
		else
		begin
			if (mem_r.rd)
				mdat_r <= mem_rdata;
			if (st_r == NRB_IDLE && start && dop != nrb_pkg::NRB_NONE)
			begin
				acc_r   <= regs_in.acc;
				flags_r <= regs_in.flags;
			end
			else if (st_r == NRB_RUN && cnt_r == len_r)
			begin
				acc_r   <= acc_nxt;
				flags_r <= flags_nxt;
			end
		end
	end

	// The done pulse is launched by the edge that closes the last state, so it is sampled one edge later.
	chk_rot_len: assert property (@(posedge clock) disable iff (srst)
		(st_r == NRB_IDLE && start && (dop == nrb_pkg::NRB_ROT_R || dop == nrb_pkg::NRB_ROT_L))
		|=> ##18 done_r)
		else $error("rotate length wrong");
	chk_bitreg_len: assert property (@(posedge clock) disable iff (srst)
		(st_r == NRB_IDLE && start && dop == nrb_pkg::NRB_BIT_REG) |=> ##8 done_r)
		else $error("register test length wrong");
	chk_bitptr_len: assert property (@(posedge clock) disable iff (srst)
		(st_r == NRB_IDLE && start && dop == nrb_pkg::NRB_BIT_PTR) |=> ##12 done_r)
		else $error("pointer test length wrong");
	chk_bitidx_len: assert property (@(posedge clock) disable iff (srst)
		(st_r == NRB_IDLE && start && dop == nrb_pkg::NRB_BIT_IDX) |=> ##20 done_r)
		else $error("indexed test length wrong");
	chk_bit_flags: assert property (@(posedge clock) disable iff (srst)
		(done_r && op_r != nrb_pkg::NRB_ROT_R && op_r != nrb_pkg::NRB_ROT_L)
		|-> flags_r[`NRB_FLAG_H] && !flags_r[`NRB_FLAG_N])
		else $error("bit test flags wrong");
	chk_rot_flags: assert property (@(posedge clock) disable iff (srst)
		(done_r && (op_r == nrb_pkg::NRB_ROT_R || op_r == nrb_pkg::NRB_ROT_L))
		|-> flags_r[`NRB_FLAG_Z] == (acc_r == 8'h00) && flags_r[`NRB_FLAG_S] == acc_r[7]
		&& flags_r[`NRB_FLAG_PV] == ~(^acc_r))
		else $error("rotate flags wrong");
	chk_acc_high: assert property (@(posedge clock) disable iff (srst)
		done_r |-> acc_r[7:4] == $past(acc_r[7:4]))
		else $error("acc high nibble changed");
	chk_no_write: assert property (@(posedge clock) disable iff (srst)
		mem_r.wr |-> (op_r == nrb_pkg::NRB_ROT_R || op_r == nrb_pkg::NRB_ROT_L))
		else $error("bit test wrote memory");
	chk_rot_write: assert property (@(posedge clock) disable iff (srst)
		(st_r == NRB_IDLE && start && (dop == nrb_pkg::NRB_ROT_R || dop == nrb_pkg::NRB_ROT_L))
		|-> ##15 mem_r.wr)
		else $error("rotate write missing");
	cov_rot_r: cover property (@(posedge clock) done_r && op_r == nrb_pkg::NRB_ROT_R);
	cov_rot_l: cover property (@(posedge clock) done_r && op_r == nrb_pkg::NRB_ROT_L);
	cov_bit_idx: cover property (@(posedge clock) done_r && op_r == nrb_pkg::NRB_BIT_IDX);
	cov_illegal: cover property (@(posedge clock) illegal_r);
endmodule : nrb_unit

// ---- verification/nrb_mem_model.sv ----
// Purpose: Memory partner holding the operand bytes that the unit reads and writes.
// Assumes: Read data is taken by the unit while rd is high; writes land on the rising edge.
// Notes: Outside a read the data lines show the inverse of the last byte, so a late sample is caught.
`timescale 1ns/1ps
module nrb_mem_model
(
	// Clock.
	input  wire logic                  clock,
	// Request from the unit.
	input  wire nrb_pkg::nrb_mem_req_t req,
	// Read data back.
	output logic [7:0]                 rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;
	int         wr_count;

	// Read data shows the addressed byte only while a read is asked for.
	assign rdata = req.rd ? mem[req.addr] : ~last_r;

	// Writes update the byte and are counted so the bench can see side effects.
	always @(posedge clock)
	begin
		if (req.rd)
			last_r <= mem[req.addr];
		if (req.wr)
		begin
			mem[req.addr] <= req.wdata;
			wr_count      <= wr_count + 1;
		end
	end

	// Start with no writes seen.
	initial
	begin
		wr_count = 0;
		last_r   = 8'h00;
	end
endmodule : nrb_mem_model

// ---- verification/nrb_unit_tb_top.sv ----
// Purpose: Self-checking bench for the nibble rotate and bit test unit.
// Assumes: Completion is seen on done_r, a refused opcode on illegal_r.
// Notes: Memory bytes not set up on purpose stay unknown, so a wrong address shows as a mismatch.
`timescale 1ns/1ps
module nrb_unit_tb_top;
	logic                  clock, srst, start, busy_r, done_r, illegal_r, b1, ill;
	logic [7:0]            pfx, op2, disp, op4, mem_rdata, acc_r, flags_r;
	nrb_pkg::nrb_regs_t    regs_in, q;
	nrb_pkg::nrb_mem_req_t mem_r;
	int                    err_total, checks, cyc, n, w0;

	nrb_unit nrb_unit_i (.clock(clock), .srst(srst), .start(start), .pfx(pfx), .op2(op2), .disp(disp),
		.op4(op4), .regs_in(regs_in), .mem_rdata(mem_rdata), .mem_r(mem_r), .acc_r(acc_r),
		.flags_r(flags_r), .busy_r(busy_r), .done_r(done_r), .illegal_r(illegal_r));
	nrb_mem_model nrb_mem_model_i (.clock(clock), .req(mem_r), .rdata(mem_rdata));

	// Clock of 25 ns period.
	always #12.5 clock = ~clock;

	// Cuts a hang short.
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_total++;
			$display("ERROR t=%0t run did not finish", $time);
			wrap_up();
		end
	end

	// Compares one value and counts it.
	task cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_val

	// Prints the counts and the verdict, then ends the run.
	task wrap_up;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// Issues one instruction and counts edges from the taking edge to completion.
	task run_op(input nrb_pkg::nrb_regs_t r, input logic [7:0] p, o, d, f);
		@(posedge clock);
		start   <= 1'h1;
		regs_in <= r;
		pfx     <= p;
		op2     <= o;
		disp    <= d;
		op4     <= f;
		@(posedge clock);
		start <= 1'h0;
		// The refusal pulse stands only until the next edge, so it is caught right after the taking edge.
		#1;
		ill = illegal_r;
		b1  = busy_r;
		n   = 0;
		while (done_r !== 1'h1 && ill !== 1'h1 && n < 30)
		begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask : run_op

	// Runs a rotate on the byte at 5000h and checks result, memory, flags and timing.
	task rot(input logic [7:0] o, a, m, input logic c);
		logic [7:0] ea;
		logic [7:0] em;
		q = '0;
		q.acc = a;
		q.flags = c ? 8'hFF : 8'h00;
		q.h = 8'h50;
		nrb_mem_model_i.mem[16'h5000] = m;
		w0 = nrb_mem_model_i.wr_count;
		ea = (o == 8'h67) ? {a[7:4], m[3:0]} : {a[7:4], m[7:4]};
		em = (o == 8'h67) ? {a[3:0], m[7:4]} : {m[3:0], a[3:0]};
		run_op(q, 8'hED, o, 8'h00, 8'h00);
		cmp_val(16'(n), 16'd18, "rotate states");
		cmp_val({14'h0000, b1, busy_r}, 16'h0002, "rotate busy span");
		cmp_val({8'h00, acc_r}, {8'h00, ea}, "rotate acc");
		cmp_val({8'h00, nrb_mem_model_i.mem[16'h5000]}, {8'h00, em}, "rotate mem");
		cmp_val({8'h00, flags_r & 8'hD7}, {8'h00, ea[7], ea == 8'h00, 3'h0, ~^ea, 1'h0, c}, "rotate flags");
		cmp_val(16'(nrb_mem_model_i.wr_count - w0), 16'd1, "rotate writes");
	endtask : rot

	// Runs a bit test and checks flags, timing and absence of side effects.
	task bit_t(input nrb_pkg::nrb_regs_t r, input logic [7:0] p, o, d, f, v, input int cy);
		logic [2:0] bs;
		bs = (p == 8'hCB) ? o[5:3] : f[5:3];
		w0 = nrb_mem_model_i.wr_count;
		run_op(r, p, o, d, f);
		cmp_val(16'(n), 16'(cy), "bit test states");
		cmp_val({8'h00, flags_r & 8'h53}, {8'h00, 1'h0, ~v[bs], 1'h0, 1'h1, 3'h0, r.flags[0]}, "bit flags");
		cmp_val({acc_r, 8'(nrb_mem_model_i.wr_count - w0)}, {r.acc, 8'h00}, "bit side effect");
	endtask : bit_t

	// Returns the register that a select code names.
	function automatic logic [7:0] pick(nrb_pkg::nrb_regs_t r, int c);
		logic [7:0] t [8];
		t = '{r.b, r.c, r.d, r.e, r.h, r.l, 8'h00, r.acc};
		return t[c];
	endfunction : pick

	// Main sequence.
	initial
	begin
		clock = 1'h0; srst = 1'h1; start = 1'h0; pfx = 8'h00; op2 = 8'h00; disp = 8'h00; op4 = 8'h00;
		regs_in = '0; err_total = 0; checks = 0; cyc = 0;
		repeat (10) @(posedge clock);
		srst <= 1'h0;
		@(posedge clock);
		#1;
		cmp_val({5'h00, busy_r, done_r, illegal_r, acc_r}, 16'h0000, "reset outputs");
		rot(8'h67, 8'h84, 8'h20, 1'h1);
		rot(8'h67, 8'h05, 8'h30, 1'h0);
		rot(8'h6F, 8'h7A, 8'h31, 1'h1);
		// Every register code with every bit position, carry in toggled.
		q = '{8'hA5, 8'h00, 8'h5A, 8'hC3, 8'h0F, 8'hF0, 8'h96, 8'h3C, 16'h7000, 16'h7000};
		for (int r = 0; r < 8; r++)
			for (int b = 0; b < 8; b++)
				if (r != 6)
				begin
					q.flags = b[0] ? 8'hFF : 8'h00;
					bit_t(q, 8'hCB, {2'h1, 3'(b), 3'(r)}, 8'h00, 8'h00, pick(q, r), 8);
				end
		// Memory forms: pointer, first index with both signs, second index.
		q.h = 8'h44; q.l = 8'h44;
		nrb_mem_model_i.mem[16'h4444] = 8'h10;
		nrb_mem_model_i.mem[16'h2004] = 8'h40;
		nrb_mem_model_i.mem[16'h1FFC] = 8'hBF;
		for (int b = 0; b < 8; b++)
		begin
			bit_t(q, 8'hCB, {2'h1, 3'(b), 3'h6}, 8'h00, 8'h00, 8'h10, 12);
			q.first_index_pair = 16'h2000;
			bit_t(q, 8'hDD, 8'hCB, 8'h04, {2'h1, 3'(b), 3'h6}, 8'h40, 20);
			bit_t(q, 8'hDD, 8'hCB, 8'hFC, {2'h1, 3'(b), 3'h6}, 8'hBF, 20);
			q.first_index_pair = 16'h7000;
			q.second_index_pair = 16'h2008;
			bit_t(q, 8'hFD, 8'hCB, 8'hFC, {2'h1, 3'(b), 3'h6}, 8'h40, 20);
			q.second_index_pair = 16'h7000;
		end
		// An opcode outside both groups is refused without going busy.
		run_op(q, 8'hED, 8'h00, 8'h00, 8'h00);
		cmp_val({14'h0000, ill, b1}, 16'h0002, "refused opcode");
		wrap_up();
	end
endmodule : nrb_unit_tb_top
